// >>> rtl/commutation_pkg.sv
// shared types and constants for the commutation block
package commutation_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam int unsigned    SYNC_STAGES     = 2;
    localparam logic [2:0]     DRIVE_OFF       = 3'h0;
    localparam logic [2:0]     DRIVE_ALL       = 3'h7;
    localparam logic           FAULT_IDLE_N    = 1'h1;

    // ------------------------------------------------------------
    // field positions of the rotor code (a is msb)
    // ------------------------------------------------------------
    localparam int unsigned    POS_SENSOR_A    = 2;
    localparam int unsigned    POS_SENSOR_B    = 1;
    localparam int unsigned    POS_SENSOR_C    = 0;

    // ------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic [2:0] sensor;
        logic       run_enable;
        logic       brake;
        logic       forward;
        logic       phase_60;
        logic       over_current;
        logic       undervoltage;
        logic       thermal;
    } ctrl_in_s;

    typedef struct packed {
        logic [2:0] upper;
        logic [2:0] lower;
    } drive_s;

    typedef enum logic [1:0] {
        MODE_COAST = 2'b00,
        MODE_RUN   = 2'b01,
        MODE_BRAKE = 2'b10,
        MODE_FAULT = 2'b11
    } mode_e;

endpackage

// >>> rtl/input_sync.sv
// two-stage synchroniser for a group of level inputs
`timescale 1ns/1ps
module input_sync
    import commutation_pkg::*;
#(
    parameter int unsigned WIDTH = 10
) (
    // clock and reset
    input  wire logic             ref_clk_i,
    input  wire logic             reset_i,
    input  wire logic             clk_en_i,
    // data
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] stage_one;
    logic [WIDTH-1:0] next_stage_one;
    logic [WIDTH-1:0] next_sync;

    // the stage count is fixed by this structure, not by a parameter
    if (WIDTH < 1 || SYNC_STAGES != 2) begin : g_bad_config
        $error("input_sync: WIDTH below 1 or stage count not two");
    end

    always_comb begin
        next_stage_one = stage_one;
        next_sync      = sync_o;
        if (clk_en_i) begin
            next_stage_one = async_i;
            next_sync      = stage_one;
        end
    end

    // first stage feeds only the second
    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            stage_one <= '0;
            sync_o    <= '0;
        end else begin
            stage_one <= next_stage_one;
            sync_o    <= next_sync;
        end
    end

endmodule

// >>> rtl/bldc_commutation_control.sv
// commutation, braking and protection logic of a three-phase motor controller
`timescale 1ns/1ps
module bldc_commutation_control
    import commutation_pkg::*;
(
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic reset_i,
    input  wire logic clk_en_i,
    // rotor sensors
    input  wire logic rotor_sensor_a_i,
    input  wire logic rotor_sensor_b_i,
    input  wire logic rotor_sensor_c_i,
    // control
    input  wire logic run_enable_i,
    input  wire logic brake_i,
    input  wire logic forward_i,
    input  wire logic phase_60_i,
    // protection
    input  wire logic over_current_i,
    input  wire logic undervoltage_i,
    input  wire logic thermal_i,
    input  wire logic osc_cycle_start_i,
    // upper drives, open collector: oe high pulls the pin low (switch on)
    output logic      upper_drive_phase_a_o,
    output logic      upper_drive_phase_a_oe_o,
    output logic      upper_drive_phase_b_o,
    output logic      upper_drive_phase_b_oe_o,
    output logic      upper_drive_phase_c_o,
    output logic      upper_drive_phase_c_oe_o,
    // lower drives, totem pole, high means switch on
    output logic      lower_drive_phase_a_o,
    output logic      lower_drive_phase_b_o,
    output logic      lower_drive_phase_c_o,
    // status
    output logic      fault_n_o,
    output logic      fault_n_oe_o,
    output mode_e     mode_o
);

    // ------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------
    ctrl_in_s raw_in;
    ctrl_in_s sync_in;

    assign raw_in = '{sensor:       {rotor_sensor_a_i, rotor_sensor_b_i, rotor_sensor_c_i},
                      run_enable:   run_enable_i,
                      brake:        brake_i,
                      forward:      forward_i,
                      phase_60:     phase_60_i,
                      over_current: over_current_i,
                      undervoltage: undervoltage_i,
                      thermal:      thermal_i};

    input_sync #(
        .WIDTH ($bits(ctrl_in_s))
    ) u_sync (
        .ref_clk_i (ref_clk_i),
        .reset_i   (reset_i),
        .clk_en_i  (clk_en_i),
        .async_i   (raw_in),
        .sync_o    (sync_in)
    );

    // ------------------------------------------------------------
    // decoding
    // ------------------------------------------------------------
    // maps a 60 degree code onto the 120 degree convention (b inverted)
    function automatic logic [2:0] to_120(input logic [2:0] code, input logic sel_60);
        to_120 = sel_60 ? {code[POS_SENSOR_A], ~code[POS_SENSOR_B], code[POS_SENSOR_C]}
                        : code;
    endfunction

    // forward table in the 120 degree convention; valid flag in bit 6
    function automatic logic [6:0] decode_step(input logic [2:0] code);
        case (code)
            3'h4:    decode_step = {1'b1, 3'h4, 3'h1}; // upper a, lower c
            3'h6:    decode_step = {1'b1, 3'h2, 3'h1}; // upper b, lower c
            3'h2:    decode_step = {1'b1, 3'h2, 3'h4}; // upper b, lower a
            3'h3:    decode_step = {1'b1, 3'h1, 3'h4}; // upper c, lower a
            3'h1:    decode_step = {1'b1, 3'h1, 3'h2}; // upper c, lower b
            3'h5:    decode_step = {1'b1, 3'h4, 3'h2}; // upper a, lower b
            default: decode_step = {1'b0, DRIVE_OFF, DRIVE_OFF};
        endcase
    endfunction

    logic [2:0] code_120;
    logic [6:0] step;
    logic       code_valid;
    drive_s     table_drive;

    always_comb begin
        code_120    = to_120(sync_in.sensor, sync_in.phase_60);
        step        = decode_step(code_120);
        code_valid  = step[6];
        table_drive = '{upper: step[5:3], lower: step[2:0]};
        if (!sync_in.forward) begin
            table_drive = '{upper: step[2:0], lower: step[5:3]};
        end
    end

    // ------------------------------------------------------------
    // cycle-by-cycle current limit latch
    // ------------------------------------------------------------
    // set wins over the cycle-start clear so no trip is lost
    logic limit_hit;
    logic next_limit_hit;

    always_comb begin
        next_limit_hit = limit_hit;
        if (clk_en_i) begin
            if (osc_cycle_start_i) next_limit_hit = 1'b0;
            if (sync_in.over_current) next_limit_hit = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) limit_hit <= 1'b0;
        else         limit_hit <= next_limit_hit;
    end

    // ------------------------------------------------------------
    // mode and drive outputs
    // ------------------------------------------------------------
    mode_e  next_mode;
    drive_s drive;
    drive_s next_drive;
    logic   fault_n;
    logic   next_fault_n;

    always_comb begin
        next_mode    = mode_o;
        next_drive   = drive;
        next_fault_n = fault_n;
        if (clk_en_i) begin
            next_fault_n = ~(!code_valid || !sync_in.run_enable || sync_in.over_current
                             || sync_in.undervoltage || sync_in.thermal);
            if (sync_in.brake) begin
                next_mode  = MODE_BRAKE;
                next_drive = '{upper: DRIVE_OFF, lower: DRIVE_ALL};
            end else if (!sync_in.run_enable) begin
                next_mode  = MODE_COAST;
                next_drive = '{upper: DRIVE_OFF, lower: DRIVE_OFF};
            end else if (!code_valid || sync_in.undervoltage || sync_in.thermal) begin
                next_mode  = MODE_FAULT;
                next_drive = '{upper: DRIVE_OFF, lower: DRIVE_OFF};
            end else begin
                next_mode  = MODE_RUN;
                next_drive = table_drive;
                // limit ends conduction for the rest of this cycle
                if (next_limit_hit) next_drive = '{upper: DRIVE_OFF, lower: DRIVE_OFF};
            end
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (reset_i) begin
            mode_o  <= MODE_COAST;
            drive   <= '{upper: DRIVE_OFF, lower: DRIVE_OFF};
            fault_n <= FAULT_IDLE_N;
        end else begin
            mode_o  <= next_mode;
            drive   <= next_drive;
            fault_n <= next_fault_n;
        end
    end

    // open-collector pins: data always low, enable pulls low
    assign upper_drive_phase_a_o    = 1'b0;
    assign upper_drive_phase_b_o    = 1'b0;
    assign upper_drive_phase_c_o    = 1'b0;
    assign upper_drive_phase_a_oe_o = drive.upper[2];
    assign upper_drive_phase_b_oe_o = drive.upper[1];
    assign upper_drive_phase_c_oe_o = drive.upper[0];
    assign lower_drive_phase_a_o    = drive.lower[2];
    assign lower_drive_phase_b_o    = drive.lower[1];
    assign lower_drive_phase_c_o    = drive.lower[0];
    assign fault_n_o                = 1'b0;
    assign fault_n_oe_o             = ~fault_n;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    brake_priority_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && sync_in.brake) |=> (drive.upper == DRIVE_OFF && drive.lower == DRIVE_ALL))
        else $error("brake did not force lower drives on");

    brake_mode_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && sync_in.brake) |=> mode_o == MODE_BRAKE)
        else $error("brake mode not entered");

    coast_drives_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && !sync_in.brake && !sync_in.run_enable)
        |=> (drive == '0 && !fault_n))
        else $error("disable did not coast with fault");

    run_follows_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && mode_o == MODE_RUN && !limit_hit) |-> $countones(drive.upper) == 1)
        else $error("running without one upper drive");

    invalid_fault_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && !code_valid) |=> (!fault_n && drive.upper == DRIVE_OFF
                                        || mode_o == MODE_BRAKE))
        else $error("invalid code not flagged");

    limit_holds_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && sync_in.over_current) |=> limit_hit ##0 (drive.upper == DRIVE_OFF))
        else $error("current limit did not end conduction");

    fault_sources_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && (sync_in.undervoltage || sync_in.thermal)) |=> fault_n_oe_o)
        else $error("fault output not asserted");

    reverse_swap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i && next_mode == MODE_RUN && !next_limit_hit && !sync_in.forward)
        |=> ({1'b1, drive.lower, drive.upper} == $past(step)))
        else $error("reverse did not swap drives");

    sync_delay_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        (clk_en_i ##1 clk_en_i) |=> sync_in.brake == $past(brake_i, 2))
        else $error("synchroniser depth wrong");

endmodule

// >>> verif/motor_partner.sv
// rotor sensors and power switches seen from the far side of the drives
`timescale 1ns/1ps
module motor_partner (
    // rotor position, steps 6 and 7 model open or shorted sensor lines
    input  wire logic [2:0] step_i,
    input  wire logic       phase_60_i,
    output logic      [2:0] sensor_o,
    // power switches
    input  wire logic [2:0] upper_oe_i,
    input  wire logic [2:0] lower_i,
    output logic      [2:0] upper_pin_o,
    output logic            shoot_o
);
    logic [2:0] code;

    always_comb begin
        case (step_i)
            3'h0: code = 3'h4;
            3'h1: code = 3'h6;
            3'h2: code = 3'h2;
            3'h3: code = 3'h3;
            3'h4: code = 3'h1;
            3'h5: code = 3'h5;
            3'h6: code = 3'h0;
            default: code = 3'h7;
        endcase
        // 60 degree sensors differ from 120 degree ones in sensor b
        sensor_o = phase_60_i ? (code ^ 3'h2) : code;
        // released collector lines rise through the pull-up
        upper_pin_o = ~upper_oe_i;
        // both switches of one leg on would short the supply
        shoot_o = |(~upper_pin_o & lower_i);
    end
endmodule

// >>> verif/bldc_commutation_control_tb.sv
// self-checking bench of the commutation and protection block
`timescale 1ns/1ps
module bldc_commutation_control_tb;
    import commutation_pkg::*;

`define CHK(g, e, m) begin tests_run++; if ((g) !== (e)) begin bad_count++; \
    $display("wrong value at %0t: %s", $time, m); end end

    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic     ref_clk_i = 0;
    logic     reset_i   = 1;
    logic     clk_en_i  = 1;
    logic     osc       = 1;
    logic [2:0] step    = 0;
    ctrl_in_s iv        = '0;
    logic [2:0] sens, up_oe, up_d, low, pin;
    logic     shoot, flt_n, flt_oe;
    mode_e    mode;
    int       bad_count = 0;
    int       tests_run = 0;
    int       cycles    = 0;

    initial forever #25 ref_clk_i = ~ref_clk_i;

    motor_partner partner (.step_i(step), .phase_60_i(iv.phase_60), .sensor_o(sens),
        .upper_oe_i(up_oe), .lower_i(low), .upper_pin_o(pin), .shoot_o(shoot));

    bldc_commutation_control dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
        .clk_en_i(clk_en_i), .rotor_sensor_a_i(sens[2]), .rotor_sensor_b_i(sens[1]),
        .rotor_sensor_c_i(sens[0]), .run_enable_i(iv.run_enable), .brake_i(iv.brake),
        .forward_i(iv.forward), .phase_60_i(iv.phase_60),
        .over_current_i(iv.over_current), .undervoltage_i(iv.undervoltage),
        .thermal_i(iv.thermal), .osc_cycle_start_i(osc),
        .upper_drive_phase_a_o(up_d[2]), .upper_drive_phase_a_oe_o(up_oe[2]),
        .upper_drive_phase_b_o(up_d[1]), .upper_drive_phase_b_oe_o(up_oe[1]),
        .upper_drive_phase_c_o(up_d[0]), .upper_drive_phase_c_oe_o(up_oe[0]),
        .lower_drive_phase_a_o(low[2]), .lower_drive_phase_b_o(low[1]),
        .lower_drive_phase_c_o(low[0]), .fault_n_o(flt_n), .fault_n_oe_o(flt_oe),
        .mode_o(mode));

    // ------------------------------------------------------------
    // expectations
    // ------------------------------------------------------------
    function automatic drive_s table_drv(input logic [2:0] c, input logic p60, fwd);
        drive_s d;
        case (p60 ? (c ^ 3'h2) : c)
            3'h4: d = '{3'h4, 3'h1};
            3'h6: d = '{3'h2, 3'h1};
            3'h2: d = '{3'h2, 3'h4};
            3'h3: d = '{3'h1, 3'h4};
            3'h1: d = '{3'h1, 3'h2};
            3'h5: d = '{3'h4, 3'h2};
            default: d = '{3'h0, 3'h0};
        endcase
        if (!fwd) d = '{d.lower, d.upper};
        return d;
    endfunction

    task automatic check_now();
        drive_s e;
        logic bad_code;
        logic exp_flt;
        mode_e m;
        e = table_drv(sens, iv.phase_60, iv.forward);
        bad_code = (e.upper == 3'h0);
        exp_flt = bad_code | ~iv.run_enable | iv.over_current | iv.undervoltage | iv.thermal;
        m = MODE_RUN;
        if (iv.brake) begin
            e = '{3'h0, 3'h7};
            m = MODE_BRAKE;
        end else if (!iv.run_enable) begin
            e = '{3'h0, 3'h0};
            m = MODE_COAST;
        end else if (bad_code || iv.undervoltage || iv.thermal) begin
            e = '{3'h0, 3'h0};
            m = MODE_FAULT;
        end else if (iv.over_current) begin
            e = '{3'h0, 3'h0};
        end
        `CHK(up_oe, e.upper, "upper drives")
        `CHK(low, e.lower, "lower drives")
        `CHK(flt_oe, exp_flt, "fault output")
        `CHK(mode, m, "mode")
        `CHK({up_d, flt_n, shoot}, 5'h0, "open collector or leg short")
    endtask

    task automatic wait_n(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask

    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // hang guard well above the roughly 1400 cycles the sequence needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        void'($urandom(55276));
        wait_n(20);
        `CHK({up_oe, low, flt_oe, mode}, 9'h0, "reset values")
        reset_i = 0;
        iv.run_enable = 1;
        iv.forward = 1;
        // every code in both phasings and both directions
        for (int i = 0; i < 32; i++) begin
            {iv.phase_60, iv.forward, step} = i[4:0];
            wait_n(4);
            check_now();
        end
        for (int i = 0; i < 300; i++) begin
            iv = 10'($urandom);
            step = 3'($urandom);
            iv.brake = ($urandom % 4 == 0);
            iv.run_enable = ($urandom % 5 != 0);
            iv.over_current = ($urandom % 6 == 0);
            iv.undervoltage = ($urandom % 8 == 0);
            iv.thermal = ($urandom % 8 == 0);
            wait_n(4);
            check_now();
        end
        // brake reaches the drives on the third edge, not sooner
        iv = '0;
        iv.run_enable = 1;
        iv.forward = 1;
        step = 0;
        wait_n(4);
        iv.brake = 1;
        wait_n(2);
        `CHK(low, 3'h1, "brake too early")
        wait_n(1);
        `CHK(low, 3'h7, "brake latency")
        // clock enable low freezes everything
        clk_en_i = 0;
        iv.brake = 0;
        wait_n(6);
        `CHK(low, 3'h7, "frozen drives")
        clk_en_i = 1;
        wait_n(4);
        check_now();
        // current limit holds until the next oscillator cycle
        osc = 0;
        step = 1;
        wait_n(4);
        check_now();
        iv.over_current = 1;
        wait_n(4);
        check_now();
        iv.over_current = 0;
        wait_n(6);
        `CHK({up_oe, low, flt_oe}, 7'h0, "limit released early")
        osc = 1;
        wait_n(1);
        osc = 0;
        wait_n(5);
        check_now();
        // a second reset in mid-run clears drives, fault and mode
        reset_i = 1;
        wait_n(2);
        `CHK({up_oe, low, flt_oe, mode}, 9'h0, "mid-run reset values")
        reset_i = 0;
        wait_n(2);
        `CHK({up_oe, low}, 6'h0, "drives before synchroniser fills")
        wait_n(2);
        check_now();
        print_verdict();
    end
endmodule
